/* File: dv/testbench.sv */
module testbench
	import uhtr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset_n = 0, in_short_done = 0, iso_start = 0;
	logic wake_pin = 0, go_operational = 0, feed_en = 0, ones = 0;
	int ack_wait = 2, n_bytes = 24, lim = 24;
	logic mem_wr_ack, mem_wr_req, mem_wr_retire, in_retry, in_done;
	logic fetch_valid, fetch_ready, tx_token, tx_valid, tx_bit, tx_hung;
	logic sof_pulse, resume_drive, resume_eop;
	uhtr_byte_t fetch_data;
	int err_count = 0, checked = 0, nb, run, n;
	logic bq[$];
	logic rq[$];
	always #50 clk = ~clk;
	uhtr_top u_dut (.clk(clk), .reset_n(reset_n), .in_short_done(in_short_done),
		.mem_wr_ack(mem_wr_ack), .mem_wr_req(mem_wr_req), .mem_wr_retire(mem_wr_retire),
		.in_retry(in_retry), .in_done(in_done), .iso_start(iso_start),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_ready(fetch_ready),
		.tx_token(tx_token), .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_hung(tx_hung),
		.sof_pulse(sof_pulse), .wake_pin(wake_pin), .go_operational(go_operational),
		.resume_drive(resume_drive), .resume_eop(resume_eop));
	uhtr_far_end u_far (.clk(clk), .reset_n(reset_n), .mem_wr_req(mem_wr_req),
		.mem_wr_ack(mem_wr_ack), .ack_wait(ack_wait), .fetch_ready(fetch_ready),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .feed_en(feed_en),
		.ones(ones), .n_bytes(n_bytes), .lim(lim));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	// ***************
	// Reference model: stuffed bit stream, token threshold, write-back order
	// ***************
	always @(posedge clk) begin
		if (iso_start) begin
			nb = 0;
			run = 0;
			bq.delete();
		end
		if (fetch_valid && fetch_ready) begin
			nb++;
			for (int i = 0; i < 8; i++) begin
				bq.push_back(fetch_data.data[i]);
				run = fetch_data.data[i] ? run + 1 : 0;
				if (run == 6) begin
					bq.push_back(1'b0);
					run = 0;
				end
			end
		end
		if (tx_token) chk("token bytes", 1, nb >= 16);
		if (tx_valid) chk("tx bit", bq.size() > 0 ? bq.pop_front() : 32'hffffffff, tx_bit);
		if (mem_wr_ack) rq.push_back(mem_wr_retire);
	end
	task automatic in_xfer(input int w, input int k);
		@(posedge clk);
		rq.delete();
		ack_wait <= w;
		in_short_done <= 1;
		@(posedge clk);
		in_short_done <= 0;
		n = 0;
		while (in_done !== 1 && in_retry !== 1 && n < 12000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("acks", k, rq.size());
		chk("status first", 0, rq[0]);
		chk("end pulse", 1, k == 2 ? in_done : in_retry);
		if (k == 2) chk("retire second", 1, rq[1]);
		$display("in transfer test ended");
	endtask : in_xfer
	task automatic wait_drive();
		n = 0;
		while (resume_drive !== 1 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("resume start", 1, n <= 6);
	endtask : wait_drive
	initial begin
		#(60000 * 100);
		err_count++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1;
		repeat (2) @(posedge clk);
		@(posedge sof_pulse);
		@(posedge clk);
		in_xfer(3, 2);
		in_xfer(10500, 1);
		@(posedge clk);
		feed_en <= 1;
		iso_start <= 1;
		@(posedge clk);
		iso_start <= 0;
		repeat (400) @(posedge clk);
		chk("bits left", 0, bq.size());
		chk("no hang", 0, tx_hung);
		feed_en <= 0;
		$display("iso out test ended");
		wake_pin <= 1;
		wait_drive();
		n = 0;
		repeat (1000) begin
			@(posedge clk);
			#1;
			if (resume_drive !== 1) n++;
		end
		chk("resume held", 0, n);
		@(posedge clk);
		go_operational <= 1;
		@(posedge clk);
		go_operational <= 0;
		#1;
		n = 0;
		while (resume_eop !== 1 && n < 3) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("eop", 1, resume_eop);
		chk("drive cut", 0, resume_drive);
		@(posedge clk);
		wake_pin <= 0;
		repeat (5) @(posedge clk);
		wake_pin <= 1;
		wait_drive();
		$display("resume test ended");
		@(posedge clk);
		ones <= 1;
		n_bytes <= 40;
		lim <= 20;
		feed_en <= 1;
		iso_start <= 1;
		@(posedge clk);
		iso_start <= 0;
		n = 0;
		while (tx_hung !== 1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("hang", 1, tx_hung);
		n = 0;
		repeat (10100) begin
			@(posedge clk);
			#1;
			if (sof_pulse !== 1'b0) n++;
		end
		chk("sof after hang", 0, n);
		$display("underrun test ended");
		conclude();
	end
endmodule : testbench

/* File: dv/uhtr_far_end.sv */
module uhtr_far_end
	import uhtr_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic reset_n, // Async reset
	input wire logic mem_wr_req, // Write-back request
	output logic mem_wr_ack, // Write accept pulse
	input wire logic [31:0] ack_wait, // Memory latency in cycles
	input wire logic fetch_ready, // FIFO space
	output logic fetch_valid, // Byte valid
	output uhtr_byte_t fetch_data, // Byte and end mark
	input wire logic feed_en, // Supply enable, low restarts packet
	input wire logic ones, // All-ones payload
	input wire logic [31:0] n_bytes, // Packet length
	input wire logic [31:0] lim // Bytes supplied before running dry
);
	timeunit 1ns;
	timeprecision 1ns;
	int wcnt;
	int sent;
	int seed = 32'h0c11537a;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_wr_ack <= 1'b0;
			wcnt <= 0;
		end else begin
			mem_wr_ack <= 1'b0;
			if (!mem_wr_req || mem_wr_ack) begin
				wcnt <= 0;
			end else begin
				wcnt <= wcnt + 1;
				if (wcnt + 1 == ack_wait) mem_wr_ack <= 1'b1;
			end
		end
	end
	// Released data lines show the inverse of the last byte
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch_valid <= 1'b0;
			fetch_data <= '0;
			sent <= 0;
		end else if (fetch_valid && fetch_ready) begin
			fetch_valid <= 1'b0;
			fetch_data <= ~fetch_data;
			sent <= sent + 1;
		end else if (!feed_en) begin
			sent <= 0;
		end else if (!fetch_valid && sent < lim) begin
			fetch_valid <= 1'b1;
			fetch_data.data <= ones ? 8'hff : 8'($random(seed));
			fetch_data.last <= (sent == n_bytes - 1);
		end
	end
endmodule : uhtr_far_end

/* File: rtl/uhtr_consts.svh */
// Operation
// [RULE1] IN completion: status write then retirement write
// [RULE2] Frame boundary during status write skips retirement
// [RULE3] Skipped retirement makes same IN token retry
// [RULE4] System finishes both write-backs inside one frame
// [RULE5] ISO OUT token after sixteen fetched bytes
// [RULE6] Underrun while bit-stuffing hangs the port
// [RULE7] Hung port stops sending start-of-frame
// [RULE8] System keeps ISO OUT data always available
// [RULE9] Remote wakeup drives resume for 20 ms
// [RULE10] Going operational mid-resume ends it with EOP
// [RULE11] Software repeats port resume after going operational
`ifndef UHTR_CONSTS_SVH
`define UHTR_CONSTS_SVH
`define UHTR_CLK_HZ 10000000
`define UHTR_FRAME_US 1000
`define UHTR_FRAME_CYC ((`UHTR_FRAME_US * (`UHTR_CLK_HZ / 1000000)))
`define UHTR_RESUME_MS 20
`define UHTR_RESUME_CYC ((`UHTR_RESUME_MS * (`UHTR_CLK_HZ / 1000)))
`define UHTR_ISO_PREFETCH 16
`define UHTR_FIFO_DEPTH 32
`define UHTR_STUFF_RUN 6
`endif

/* File: rtl/uhtr_fifo.sv */
module uhtr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic clk, // Clock
	input wire logic reset_n, // Async reset
	input wire logic in_valid, // Write valid
	output logic in_ready, // Not full
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Not empty
	input wire logic out_ready, // Read accept
	output logic [WIDTH-1:0] out_data, // Head data
	output logic [$clog2(DEPTH):0] count // Fill level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic wr;
	logic rd;
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
	assign count = cnt_q;
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (wr) begin
			mem[wp_q] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule : uhtr_fifo

/* File: rtl/uhtr_pkg.sv */
package uhtr_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} uhtr_byte_t;
	typedef enum logic [1:0] {
		UHTR_WB_IDLE = 2'b00,
		UHTR_WB_STATUS = 2'b01,
		UHTR_WB_RETIRE = 2'b10
	} uhtr_wb_t;
	typedef enum logic [1:0] {
		UHTR_TX_IDLE = 2'b00,
		UHTR_TX_FILL = 2'b01,
		UHTR_TX_SEND = 2'b10,
		UHTR_TX_HUNG = 2'b11
	} uhtr_tx_t;
endpackage : uhtr_pkg

/* File: rtl/uhtr_top.sv */
`include "uhtr_consts.svh"
module uhtr_top
	import uhtr_pkg::*;
(
	input wire logic clk, // 10 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic in_short_done, // Short IN data stored in memory, pulse
	input wire logic mem_wr_ack, // Memory write accepted, pulse
	output logic mem_wr_req, // Write-back request level
	output logic mem_wr_retire, // 1: retirement write, 0: status write
	output logic in_retry, // Same IN token reissued, pulse
	output logic in_done, // IN transfer retired, pulse
	input wire logic iso_start, // Start ISO OUT packet, pulse
	input wire logic fetch_valid, // Fetched byte valid
	input wire uhtr_byte_t fetch_data, // Fetched byte and last marker
	output logic fetch_ready, // FIFO can take a byte
	output logic tx_token, // ISO OUT token issued, pulse
	output logic tx_valid, // Bit stream valid
	output logic tx_bit, // Serialised bit (stuffed)
	output logic tx_hung, // Port hung level
	output logic sof_pulse, // Start-of-frame, pulse
	input wire logic wake_pin, // Remote wakeup from downstream port
	input wire logic go_operational, // Driver sets operational, pulse
	output logic resume_drive, // Resume signaling level
	output logic resume_eop // EOP ending resume, pulse
);
	// ***************
	// Frame timing
	// ***************
	localparam logic [13:0] FRAME_LAST = 14'(`UHTR_FRAME_CYC - 1);
	logic [13:0] frame_q;
	logic frame_edge;
	uhtr_tx_t tx_q;
	assign frame_edge = (frame_q == FRAME_LAST);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_q <= '0;
			sof_pulse <= 1'b0;
		end else begin
			frame_q <= frame_edge ? '0 : frame_q + 14'h0001;
			sof_pulse <= frame_edge && (tx_q != UHTR_TX_HUNG); // RULE7
		end
	end
	// ***************
	// IN write-back
	// ***************
	uhtr_wb_t wb_q;
	logic crossed_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_q <= UHTR_WB_IDLE;
			crossed_q <= 1'b0;
			mem_wr_req <= 1'b0;
			mem_wr_retire <= 1'b0;
			in_retry <= 1'b0;
			in_done <= 1'b0;
		end else begin
			in_retry <= 1'b0;
			in_done <= 1'b0;
			case (wb_q)
			UHTR_WB_IDLE: begin
				crossed_q <= 1'b0;
				if (in_short_done) begin
					wb_q <= UHTR_WB_STATUS; // RULE1
					mem_wr_req <= 1'b1;
					mem_wr_retire <= 1'b0;
				end
			end
			UHTR_WB_STATUS: begin
				if (frame_edge) begin
					crossed_q <= 1'b1;
				end
				if (mem_wr_ack) begin
					if (crossed_q || frame_edge) begin
						wb_q <= UHTR_WB_IDLE; // RULE2
						mem_wr_req <= 1'b0;
						in_retry <= 1'b1; // RULE3
					end else begin
						wb_q <= UHTR_WB_RETIRE; // RULE1
						mem_wr_retire <= 1'b1;
					end
				end
			end
			UHTR_WB_RETIRE: begin
				if (mem_wr_ack) begin
					wb_q <= UHTR_WB_IDLE;
					mem_wr_req <= 1'b0;
					mem_wr_retire <= 1'b0;
					in_done <= 1'b1;
				end
			end
			default: wb_q <= UHTR_WB_IDLE;
			endcase
		end
	end
	// ***************
	// ISO OUT path
	// ***************
	logic f_valid;
	logic f_ready;
	logic f_in_ready;
	logic [8:0] f_data;
	logic [7:0] f_byte;
	logic f_last;
	logic [5:0] f_count;
	logic [2:0] bit_q;
	logic [2:0] ones_q;
	logic stuff;
	logic last_q;
	uhtr_fifo #(.WIDTH(9), .DEPTH(`UHTR_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(fetch_valid && fetch_ready),
		.in_ready(f_in_ready),
		.in_data(fetch_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data),
		.count(f_count)
	);
	// Payload sits above the end marker in the packed word
	assign f_byte = f_data[8:1];
	assign f_last = f_data[0];
	assign stuff = (ones_q == 3'(`UHTR_STUFF_RUN));
	assign f_ready = (tx_q == UHTR_TX_SEND) && f_valid && !stuff && !last_q && (bit_q == 3'h7);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch_ready <= 1'b0;
		end else begin
			fetch_ready <= f_in_ready && (f_count < 6'(`UHTR_FIFO_DEPTH - 1));
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_q <= UHTR_TX_IDLE;
			tx_token <= 1'b0;
			tx_valid <= 1'b0;
			tx_bit <= 1'b0;
			tx_hung <= 1'b0;
			bit_q <= '0;
			ones_q <= '0;
			last_q <= 1'b0;
		end else begin
			tx_token <= 1'b0;
			case (tx_q)
			UHTR_TX_IDLE: begin
				tx_valid <= 1'b0;
				if (iso_start) begin
					tx_q <= UHTR_TX_FILL;
				end
			end
			UHTR_TX_FILL: begin
				if (f_count >= 6'(`UHTR_ISO_PREFETCH)) begin
					tx_q <= UHTR_TX_SEND; // RULE5
					tx_token <= 1'b1;
					bit_q <= '0;
					ones_q <= '0;
					last_q <= 1'b0;
				end
			end
			UHTR_TX_SEND: begin
				if (stuff) begin
					tx_valid <= 1'b1;
					tx_bit <= 1'b0;
					ones_q <= '0;
				end else if (last_q) begin
					// Leave only after a stuff bit owed by the last byte is out
					tx_valid <= 1'b0;
					tx_q <= UHTR_TX_IDLE;
				end else if (!f_valid) begin
					tx_valid <= 1'b0;
					if (ones_q != '0) begin
						tx_q <= UHTR_TX_HUNG; // RULE6
						tx_hung <= 1'b1;
					end
				end else begin
					tx_valid <= 1'b1;
					tx_bit <= f_byte[bit_q];
					ones_q <= f_byte[bit_q] ? ones_q + 3'h1 : 3'h0;
					bit_q <= bit_q + 3'h1;
					last_q <= (bit_q == 3'h7) && f_last;
				end
			end
			UHTR_TX_HUNG: begin
				tx_valid <= 1'b0; // RULE7
			end
			default: tx_q <= UHTR_TX_IDLE;
			endcase
		end
	end
	// ***************
	// Resume signaling
	// ***************
	localparam logic [17:0] RESUME_LAST = 18'(`UHTR_RESUME_CYC - 1);
	logic wake_s1_q;
	logic wake_s2_q;
	logic wake_prev_q;
	logic [17:0] res_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
			wake_prev_q <= 1'b0;
		end else begin
			wake_s1_q <= wake_pin;
			wake_s2_q <= wake_s1_q;
			wake_prev_q <= wake_s2_q;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resume_drive <= 1'b0;
			resume_eop <= 1'b0;
			res_q <= '0;
		end else begin
			resume_eop <= 1'b0;
			if (resume_drive) begin
				if (go_operational || res_q == RESUME_LAST) begin
					resume_drive <= 1'b0; // RULE10
					resume_eop <= 1'b1;
				end
				res_q <= res_q + 18'h00001;
			end else if (wake_s2_q && !wake_prev_q) begin
				resume_drive <= 1'b1; // RULE9
				res_q <= '0;
			end
		end
	end
	// ***************
	// Checks
	// ***************
	sequence s_status_ack;
		wb_q == UHTR_WB_STATUS && mem_wr_ack && !crossed_q && !frame_edge;
	endsequence
	chk_retire_follows: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
		s_status_ack |=> mem_wr_req && mem_wr_retire)
		else $error("retirement write did not follow status write");
	chk_skip_retire: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
		(wb_q == UHTR_WB_STATUS && mem_wr_ack && (crossed_q || frame_edge))
		|=> !mem_wr_req && wb_q == UHTR_WB_IDLE)
		else $error("retirement not skipped after frame crossing");
	chk_in_retry: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
		in_retry |-> $past(wb_q) == UHTR_WB_STATUS && !in_done)
		else $error("retry without skipped retirement");
	chk_token_fill: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
		$rose(tx_token) |-> $past(f_count) >= 6'(`UHTR_ISO_PREFETCH) && tx_q == UHTR_TX_SEND)
		else $error("token issued before prefetch");
	chk_hang_stuck: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
		tx_hung |=> tx_hung && tx_q == UHTR_TX_HUNG)
		else $error("hang released");
	chk_no_sof: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
		tx_hung |-> ##1 !sof_pulse [*3])
		else $error("sof while hung");
	chk_resume_len: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
		$fell(resume_drive) |-> $past(go_operational) || $past(res_q) == RESUME_LAST)
		else $error("resume dropped early");
	chk_resume_cut: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
		(resume_drive && go_operational) |=> !resume_drive && resume_eop)
		else $error("resume not cut with eop");
endmodule : uhtr_top
